// ---- pskm_defs.vh ----
// Constants for the two-wire keyboard/mouse host block
`ifndef PSKM_DEFS_VH
`define PSKM_DEFS_VH
// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define PSKM_OFF_CTRL      12'h000
`define PSKM_OFF_STATUS    12'h004
`define PSKM_OFF_RXDATA    12'h008
`define PSKM_OFF_KEY       12'h00C
`define PSKM_OFF_MOUSE     12'h010
`define PSKM_OFF_TXDATA    12'h014
`define PSKM_OFF_LEDS      12'h018
`define PSKM_OFF_RATE      12'h01C
// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define PSKM_CTRL_TXEN     0
`define PSKM_CTRL_MOUSE    1
`define PSKM_CTRL_INHIBIT  2
`define PSKM_CTRL_RESET    8'h00
// ----------------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------------
`define PSKM_ST_RXVALID    0
`define PSKM_ST_ERR        1
`define PSKM_ST_KEYVALID   2
`define PSKM_ST_MVALID     3
`define PSKM_ST_TXBUSY     4
`define PSKM_ST_ACK        5
`define PSKM_ST_ECHO       6
`define PSKM_ST_SHIFT      7
// ----------------------------------------------------------------------------
// Link codes
// ----------------------------------------------------------------------------
`define PSKM_CODE_KEYUP    8'hF0
`define PSKM_CODE_EXT      8'hE0
`define PSKM_CODE_LEDS     8'hED
`define PSKM_CODE_RATE     8'hF3
`define PSKM_CODE_ACK      8'hFA
`define PSKM_CODE_ECHO     8'hEE
`define PSKM_CODE_LSHIFT   8'h12
`define PSKM_CODE_RSHIFT   8'h59
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PSKM_CLK_MHZ       250
`define PSKM_INHIBIT_US    100
`define PSKM_INHIBIT_CYC   (`PSKM_INHIBIT_US * `PSKM_CLK_MHZ)
`define PSKM_FILT_CYC      4'h8
`define PSKM_WORD_BITS     4'hB
`endif

// ---- pskm_host.v ----
// APB keyboard/mouse host: link receiver, decoders and command sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pskm_defs.vh"
module pskm_host #(
  parameter INHIBIT_CYC = `PSKM_INHIBIT_CYC
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        aux_serial_clock_i,
  output wire        aux_serial_clock_o,
  output wire        aux_serial_clock_oe,
  input  wire        aux_serial_data_i,
  output wire        aux_serial_data_o,
  output wire        aux_serial_data_oe
);
  // ---------------------------------------------------------------------------
  // Pin synchronisers and clock glitch filter
  // ---------------------------------------------------------------------------
  reg [1:0] clk_sync_reg;
  reg [1:0] dat_sync_reg;
  reg       clk_filt_reg;
  reg [3:0] filt_cnt_reg;
  wire      clk_fall;
  // Two flops per pin before any logic
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sync_reg <= 2'h3;
      dat_sync_reg <= 2'h3;
    end else begin
      clk_sync_reg <= {clk_sync_reg[0], aux_serial_clock_i};
      dat_sync_reg <= {dat_sync_reg[0], aux_serial_data_i};
    end
  end
  // Filtered clock changes only after a stable run
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_filt_reg <= 1'b1;
      filt_cnt_reg <= 4'h0;
    end else if (clk_sync_reg[1] == clk_filt_reg) begin
      filt_cnt_reg <= 4'h0;
    end else if (filt_cnt_reg == `PSKM_FILT_CYC) begin
      clk_filt_reg <= clk_sync_reg[1];
      filt_cnt_reg <= 4'h0;
    end else begin
      filt_cnt_reg <= filt_cnt_reg + 4'h1;
    end
  end
  // Falling edge of the filtered link clock
  assign clk_fall = (filt_cnt_reg == `PSKM_FILT_CYC) & clk_filt_reg & ~clk_sync_reg[1];
  // ---------------------------------------------------------------------------
  // Registers and APB slave
  // ---------------------------------------------------------------------------
  reg  [7:0]  ctrl_reg;
  reg  [7:0]  rxdata_reg;
  reg  [9:0]  key_reg;
  reg  [23:0] mouse_reg;
  reg  [7:0]  leds_reg;
  reg  [7:0]  rate_reg;
  reg         rxvalid_reg;
  reg         err_reg;
  reg         keyvalid_reg;
  reg         mvalid_reg;
  reg         ack_reg;
  reg         echo_reg;
  reg         lshift_reg;
  reg         rshift_reg;
  wire        wr_en;
  wire        rd_en;
  wire        tx_busy;
  wire        tx_done;
  wire        tx_clk_oe;
  wire        tx_dat_oe;
  wire        mapped;
  wire [7:0]  status_w;
  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign mapped  = (paddr[11:5] == 7'h00) & (paddr[1:0] == 2'h0);
  assign pslverr = psel & penable & ~mapped;
  assign status_w = {lshift_reg | rshift_reg, echo_reg, ack_reg, tx_busy,
                     mvalid_reg, keyvalid_reg, err_reg, rxvalid_reg};
  // Read mux; unmapped reads return zero
  always @* begin
    case (paddr)
      `PSKM_OFF_CTRL:   prdata = {24'h0, ctrl_reg};
      `PSKM_OFF_STATUS: prdata = {24'h0, status_w};
      `PSKM_OFF_RXDATA: prdata = {24'h0, rxdata_reg};
      `PSKM_OFF_KEY:    prdata = {22'h0, key_reg};
      `PSKM_OFF_MOUSE:  prdata = {8'h0, mouse_reg};
      `PSKM_OFF_LEDS:   prdata = {24'h0, leds_reg};
      `PSKM_OFF_RATE:   prdata = {24'h0, rate_reg};
      default:          prdata = 32'h0;
    endcase
  end
  // Control register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `PSKM_CTRL_RESET;
    end else if (wr_en && paddr == `PSKM_OFF_CTRL) begin
      ctrl_reg <= {5'h0, pwdata[2:0]};
    end
  end
  // ---------------------------------------------------------------------------
  // Word receiver
  // ---------------------------------------------------------------------------
  reg  [3:0]  rbit_reg;
  reg  [10:0] rshift_w_reg;
  reg         word_ok_reg;
  reg         word_bad_reg;
  wire [10:0] word_w;
  wire        rx_allow;
  assign word_w   = {dat_sync_reg[1], rshift_w_reg[10:1]};
  assign rx_allow = ~tx_busy & ~ctrl_reg[`PSKM_CTRL_INHIBIT];
  // Capture data on each falling link clock edge while not sending or inhibited
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rbit_reg     <= 4'h0;
      rshift_w_reg <= 11'h0;
      word_ok_reg  <= 1'b0;
      word_bad_reg <= 1'b0;
    end else begin
      word_ok_reg  <= 1'b0;
      word_bad_reg <= 1'b0;
      if (!rx_allow) begin
        rbit_reg <= 4'h0;
      end else if (clk_fall) begin
        rshift_w_reg <= word_w;
        if (rbit_reg == `PSKM_WORD_BITS - 4'h1) begin
          rbit_reg <= 4'h0;
          // Start 0, stop 1, odd parity over data and parity
          if (!word_w[0] && word_w[10] && (^word_w[9:1]))
            word_ok_reg <= 1'b1;
          else
            word_bad_reg <= 1'b1;
        end else begin
          rbit_reg <= rbit_reg + 4'h1;
        end
      end
    end
  end
  // ---------------------------------------------------------------------------
  // Keyboard, mouse decoders and status flags
  // ---------------------------------------------------------------------------
  wire [7:0] rx_byte;
  reg        brk_reg;
  reg        ext_reg;
  reg  [1:0] mcnt_reg;
  reg  [7:0] mb0_reg;
  reg  [7:0] mb1_reg;
  wire       clr_st;
  assign rx_byte = rshift_w_reg[8:1];
  assign clr_st  = wr_en && paddr == `PSKM_OFF_STATUS;
  // Byte decode and status flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxdata_reg <= 8'h0;    rxvalid_reg <= 1'b0; err_reg  <= 1'b0;
      key_reg    <= 10'h0;   keyvalid_reg <= 1'b0; brk_reg <= 1'b0;
      ext_reg    <= 1'b0;    mouse_reg   <= 24'h0; mvalid_reg <= 1'b0;
      mcnt_reg   <= 2'h0;    mb0_reg     <= 8'h0;  mb1_reg  <= 8'h0;
      ack_reg    <= 1'b0;    echo_reg    <= 1'b0;
      lshift_reg <= 1'b0;    rshift_reg  <= 1'b0;
    end else begin
      // Write one clears; a new event in the same cycle wins
      if (clr_st) begin
        rxvalid_reg  <= rxvalid_reg  & ~pwdata[`PSKM_ST_RXVALID];
        err_reg      <= err_reg      & ~pwdata[`PSKM_ST_ERR];
        keyvalid_reg <= keyvalid_reg & ~pwdata[`PSKM_ST_KEYVALID];
        mvalid_reg   <= mvalid_reg   & ~pwdata[`PSKM_ST_MVALID];
        ack_reg      <= ack_reg      & ~pwdata[`PSKM_ST_ACK];
        echo_reg     <= echo_reg     & ~pwdata[`PSKM_ST_ECHO];
      end
      if (word_bad_reg) begin
        err_reg <= 1'b1; // Byte dropped
      end
      if (word_ok_reg) begin
        rxdata_reg  <= rx_byte;
        rxvalid_reg <= 1'b1;
        if (ctrl_reg[`PSKM_CTRL_MOUSE]) begin
          // Three-byte packet: status, X, Y
          case (mcnt_reg)
            2'h0: begin
              mb0_reg  <= rx_byte;
              mcnt_reg <= 2'h1;
            end
            2'h1: begin
              mb1_reg  <= rx_byte;
              mcnt_reg <= 2'h2;
            end
            default: begin
              // Status byte keeps signs, overflows, buttons as sent
              mouse_reg  <= {rx_byte, mb1_reg, mb0_reg};
              mvalid_reg <= 1'b1;
              mcnt_reg   <= 2'h0;
            end
          endcase
        end else if (rx_byte == `PSKM_CODE_ACK) begin
          ack_reg <= 1'b1;
        end else if (rx_byte == `PSKM_CODE_ECHO) begin
          echo_reg <= 1'b1;
        end else if (rx_byte == `PSKM_CODE_KEYUP) begin
          brk_reg <= 1'b1;
        end else if (rx_byte == `PSKM_CODE_EXT) begin
          ext_reg <= 1'b1;
        end else begin
          // Key word: bit9 release, bit8 extended, scan code
          key_reg      <= {brk_reg, ext_reg, rx_byte};
          keyvalid_reg <= 1'b1;
          brk_reg      <= 1'b0;
          ext_reg      <= 1'b0;
          // Shift state tracked here
          if (!ext_reg && rx_byte == `PSKM_CODE_LSHIFT)
            lshift_reg <= ~brk_reg;
          if (!ext_reg && rx_byte == `PSKM_CODE_RSHIFT)
            rshift_reg <= ~brk_reg;
        end
      end
    end
  end
  // ---------------------------------------------------------------------------
  // Command sender: byte writes, LED and rate two-byte sequences
  // ---------------------------------------------------------------------------
  localparam Q_IDLE = 2'h0;
  localparam Q_WAIT = 2'h1;
  localparam Q_ACK  = 2'h2;
  localparam Q_ARG  = 2'h3;
  reg  [1:0] seq_reg;
  reg  [7:0] arg_reg;
  reg  [7:0] txbyte_reg;
  reg        txgo_reg;
  wire       sw_tx;
  // Sending from a write needs the enable; an argument byte due after FA is sent even if the enable was cleared meanwhile
  // A host that never set the enable drives no data and pulls the clock only while the inhibit bit is set
  assign sw_tx = wr_en & ctrl_reg[`PSKM_CTRL_TXEN] & (seq_reg == Q_IDLE) & ~tx_busy;
  // Command sequencer: raw byte, or command then argument after FA
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg    <= Q_IDLE;
      arg_reg    <= 8'h0;
      txbyte_reg <= 8'h0;
      txgo_reg   <= 1'b0;
      leds_reg   <= 8'h0;
      rate_reg   <= 8'h0;
    end else begin
      txgo_reg <= 1'b0;
      case (seq_reg)
        Q_IDLE: begin
          if (sw_tx && paddr == `PSKM_OFF_TXDATA) begin
            txbyte_reg <= pwdata[7:0]; // Any command, e.g. EE, FE, FF
            txgo_reg   <= 1'b1;
          end else if (sw_tx && paddr == `PSKM_OFF_LEDS) begin
            // Scroll bit 0, num bit 1, caps bit 2; upper bits dropped
            leds_reg   <= {5'h0, pwdata[2:0]};
            arg_reg    <= {5'h0, pwdata[2:0]};
            txbyte_reg <= `PSKM_CODE_LEDS;
            txgo_reg   <= 1'b1;
            seq_reg    <= Q_WAIT;
          end else if (sw_tx && paddr == `PSKM_OFF_RATE) begin
            rate_reg   <= pwdata[7:0];
            arg_reg    <= pwdata[7:0];
            txbyte_reg <= `PSKM_CODE_RATE;
            txgo_reg   <= 1'b1;
            seq_reg    <= Q_WAIT;
          end
        end
        Q_WAIT: begin
          if (tx_done) seq_reg <= Q_ACK;
        end
        Q_ACK: begin
          // Argument byte only after the FA reply
          if (word_ok_reg && rx_byte == `PSKM_CODE_ACK) begin
            txbyte_reg <= arg_reg;
            txgo_reg   <= 1'b1;
            seq_reg    <= Q_ARG;
          end else if (word_ok_reg || word_bad_reg) begin
            seq_reg <= Q_IDLE;
          end
        end
        Q_ARG: begin
          if (tx_done) seq_reg <= Q_IDLE;
        end
        default: seq_reg <= Q_IDLE;
      endcase
    end
  end
  pskm_tx #(
    .INHIBIT_CYC (INHIBIT_CYC)
  ) u_tx (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (txgo_reg),
    .byte_in  (txbyte_reg),
    .clk_fall (clk_fall),
    .line_clk (clk_filt_reg),
    .busy     (tx_busy),
    .done     (tx_done),
    .clk_oe   (tx_clk_oe),
    .dat_oe   (tx_dat_oe)
  );
  // Open-collector: only pull low, release otherwise
  assign aux_serial_clock_o  = 1'b0;
  assign aux_serial_data_o   = 1'b0;
  assign aux_serial_clock_oe = tx_clk_oe | ctrl_reg[`PSKM_CTRL_INHIBIT];
  assign aux_serial_data_oe  = tx_dat_oe;
endmodule // pskm_host
`default_nettype wire

// ---- pskm_host_assertions.sv ----
// Port-level checker for the keyboard/mouse host
`timescale 1ns/1ps
`default_nettype none
module pskm_host_chk #(
  parameter INHIBIT_CYC = 50
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        aux_serial_clock_i,
  input wire logic        aux_serial_clock_o,
  input wire logic        aux_serial_clock_oe,
  input wire logic        aux_serial_data_i,
  input wire logic        aux_serial_data_o,
  input wire logic        aux_serial_data_oe
);
  // --------------------------------------------------------------------------
  // Helper state
  // --------------------------------------------------------------------------
  logic        inh_reg;
  logic        armed_reg;
  logic [15:0] hold_cnt_reg;
  wire         wr_acc   = psel && penable && pwrite && pready;
  wire         bad_addr = (paddr > 12'h01C) || (paddr[1:0] != 2'h0);
  // Inhibit bit copy, send requests seen, clock hold length
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inh_reg      <= 1'b0;
      armed_reg    <= 1'b0;
      hold_cnt_reg <= 16'h0000;
    end else begin
      if (wr_acc && paddr == 12'h000)
        inh_reg <= pwdata[2];
      if (wr_acc && paddr >= 12'h014 && paddr <= 12'h01C)
        armed_reg <= 1'b1;
      hold_cnt_reg <= aux_serial_clock_oe ? hold_cnt_reg + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // --------------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------------
  a_clk_open_drain: assert property (aux_serial_clock_o == 1'b0)
    else $error("clock line driven high");
  a_dat_open_drain: assert property (aux_serial_data_o == 1'b0)
    else $error("data line driven high");
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  a_slverr_bad: assert property (psel && penable && bad_addr |-> pslverr)
    else $error("unmapped access not flagged");
  a_slverr_good: assert property (psel && penable && !bad_addr |-> !pslverr)
    else $error("mapped access flagged");
  a_line_quiet: assert property (!armed_reg && !inh_reg && !$past(inh_reg) &&
    !$past(inh_reg, 2) |-> !aux_serial_clock_oe && !aux_serial_data_oe)
    else $error("link driven while idle");
  a_inhibit_len: assert property ($fell(aux_serial_clock_oe) |->
    hold_cnt_reg >= INHIBIT_CYC)
    else $error("clock hold too short");
  a_inhibit_ctrl: assert property ($rose(inh_reg) |-> ##[0:2] aux_serial_clock_oe)
    else $error("inhibit not applied");
  a_inhibit_hold: assert property (inh_reg [*4] |-> aux_serial_clock_oe)
    else $error("inhibit dropped");
  c_inhibit: cover property (inh_reg ##1 aux_serial_clock_oe);
  c_request: cover property ($fell(aux_serial_clock_oe) && aux_serial_data_oe);
  c_slverr: cover property (psel && penable && pslverr);
endmodule // pskm_host_chk
bind pskm_host pskm_host_chk #(.INHIBIT_CYC(INHIBIT_CYC)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .aux_serial_clock_i(aux_serial_clock_i), .aux_serial_clock_o(aux_serial_clock_o),
  .aux_serial_clock_oe(aux_serial_clock_oe), .aux_serial_data_i(aux_serial_data_i),
  .aux_serial_data_o(aux_serial_data_o), .aux_serial_data_oe(aux_serial_data_oe)
);
`default_nettype wire

// ---- pskm_host_tb_top.sv ----
// Self-checking bench for the keyboard/mouse host
`timescale 1ns/1ps
`default_nettype none
module pskm_host_tb_top;
  // --------------------------------------------------------------------------
  // Signals and instances
  // --------------------------------------------------------------------------
  localparam int INH = 50;  // Shortened clock hold
  logic        pclk = 1'b0;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         clk_oe;
  wire         dat_oe;
  wire         clk_oe_m;
  wire         dat_oe_m;
  wire         clk_line = ~(clk_oe | clk_oe_m);  // Pulled up
  wire         dat_line = ~(dat_oe | dat_oe_m);
  logic [31:0] rd_q;
  logic        se_q;
  logic [31:0] rd;
  integer      err_count = 0;
  integer      total_checks = 0;
  pskm_host #(.INHIBIT_CYC(INH)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .aux_serial_clock_i(clk_line), .aux_serial_clock_o(), .aux_serial_clock_oe(clk_oe),
    .aux_serial_data_i(dat_line), .aux_serial_data_o(), .aux_serial_data_oe(dat_oe));
  pskm_periph_model peer (
    .clk_oe_m(clk_oe_m), .dat_oe_m(dat_oe_m), .clk_line(clk_line), .dat_line(dat_line));
  always #2 pclk = ~pclk;
  // Capture read data at the completing edge
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      rd_q <= prdata;
      se_q <= pslverr;
    end
  end
  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    rd = rd_q;
  endtask
  task automatic close_out();
    if (err_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Key bytes in, then key, last byte and flags out
  task automatic t_key(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                       input int n, input logic [31:0] k, input logic [31:0] st);
    if (n > 2)
      peer.send_byte(b0, 1'b0);
    if (n > 1)
      peer.send_byte(b1, 1'b0);
    peer.send_byte(b2, 1'b0);
    @(posedge pclk);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, k);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, {24'h0, b2});
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, st);
    apb(1'b1, 12'h004, 32'hFF);
  endtask
  // Register write, bytes seen by the peer, reply flags
  task automatic t_tx(input logic [11:0] a, input logic [31:0] d, input int n,
                      input logic [7:0] e0, input logic [7:0] e1, input logic [31:0] st);
    peer.got_q.delete();
    apb(1'b1, a, d);
    for (int i = 0; i < 3000 && (peer.got_q.size() < n || peer.busy_m); i++)
      @(posedge pclk);
    @(posedge pclk);
    chk(peer.got_q.size(), n);
    chk(peer.got_q[0], e0);
    if (n > 1)
      chk(peer.got_q[1], e1);
    chk(peer.rx_bad, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'h60, st);
    apb(1'b1, 12'h004, 32'hFF);
  endtask
  // --------------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------------
  initial begin
    #300us;
    err_count++;
    close_out();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({30'h0, clk_line, dat_line}, 32'h3);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, se_q}, 32'h1);
    t_key(8'h00, 8'h00, 8'h1C, 1, 32'h01C, 32'h05);
    t_key(8'h00, 8'h1C, 8'h1C, 2, 32'h01C, 32'h05);
    t_key(8'h00, 8'hF0, 8'h1C, 2, 32'h21C, 32'h05);
    t_key(8'h00, 8'hE0, 8'h75, 2, 32'h175, 32'h05);
    t_key(8'hE0, 8'hF0, 8'h75, 3, 32'h375, 32'h05);
    t_key(8'h00, 8'h00, 8'h12, 1, 32'h012, 32'h85);
    t_key(8'h00, 8'hF0, 8'h12, 2, 32'h212, 32'h05);
    peer.send_byte(8'h33, 1'b1);
    @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h12);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'h7, 32'h2);
    apb(1'b1, 12'h004, 32'hFF);
    apb(1'b1, 12'h000, 32'h2);
    repeat (2) begin
      peer.send_byte(8'hFB, 1'b0);
      peer.send_byte(8'h01, 1'b0);
      peer.send_byte(8'hFF, 1'b0);
    end
    @(posedge pclk);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h00FF01FB);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'hD, 32'h9);
    apb(1'b1, 12'h004, 32'hFF);
    apb(1'b1, 12'h000, 32'h4);
    fork
      peer.send_byte(8'h29, 1'b0);
      begin
        repeat (100) @(posedge pclk);
        chk({31'h0, clk_line}, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h000, 32'h0);
      end
    join
    @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h29);
    apb(1'b1, 12'h004, 32'hFF);
    apb(1'b1, 12'h000, 32'h1);
    t_tx(12'h018, 32'hFD, 2, 8'hED, 8'h05, 32'h20);
    t_tx(12'h01C, 32'h2A, 2, 8'hF3, 8'h2A, 32'h20);
    apb(1'b0, 12'h018, 32'h0);
    chk(rd, 32'h05);
    apb(1'b0, 12'h01C, 32'h0);
    chk(rd, 32'h2A);
    t_tx(12'h014, 32'hEE, 1, 8'hEE, 8'h00, 32'h40);
    t_tx(12'h014, 32'hFE, 1, 8'hFE, 8'h00, 32'h40);
    apb(1'b1, 12'h000, 32'h0);
    peer.got_q.delete();
    apb(1'b1, 12'h018, 32'h07);
    repeat (600) @(posedge pclk);
    chk(peer.got_q.size(), 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    chk(rd, 32'h05);
    close_out();
  end
endmodule // pskm_host_tb_top
`default_nettype wire

// ---- pskm_periph_model.sv ----
// Behavioural keyboard/mouse peripheral on the far side of the link
`timescale 1ns/1ps
`default_nettype none
module pskm_periph_model (
  output var logic clk_oe_m,
  output var logic dat_oe_m,
  input wire logic clk_line,
  input wire logic dat_line
);
  // --------------------------------------------------------------------------
  // Link state
  // --------------------------------------------------------------------------
  localparam time HALF = 48;  // Link clock phase
  logic [7:0] got_q[$];       // Bytes taken from the host
  logic       rx_bad  = 1'b0; // Host framing fault seen
  logic       sending = 1'b0;
  logic       busy_m  = 1'b0;
  logic [7:0] last_tx = 8'h00;
  initial begin
    clk_oe_m = 1'b0;
    dat_oe_m = 1'b0;
  end
  // One word to the host, start bit first
  task automatic send_byte(input logic [7:0] b, input logic bad_par);
    logic [10:0] w;
    w = {1'b1, (~^b) ^ bad_par, b, 1'b0};
    #(HALF * 2);
    wait (clk_line === 1'b1 && dat_line === 1'b1);
    #(HALF + 1);  // Let the host see idle; stay off its clock edges
    sending = 1'b1;
    for (int i = 0; i < 11; i++) begin
      dat_oe_m = ~w[i];
      #(HALF / 2);
      clk_oe_m = 1'b1;
      #HALF;
      clk_oe_m = 1'b0;
      #(HALF / 2);
    end
    dat_oe_m = 1'b0;
    sending = 1'b0;
    last_tx = b;
  endtask
  // Host request: clock ten bits in, acknowledge, then reply
  always begin : take_cmd
    logic [9:0] w;
    wait (clk_line === 1'b0 && !clk_oe_m && !sending);
    wait (clk_line === 1'b1 && dat_line === 1'b0 && !sending);
    busy_m = 1'b1;
    #(HALF + 1);
    for (int i = 0; i < 10; i++) begin
      clk_oe_m = 1'b1;
      #HALF;
      clk_oe_m = 1'b0;
      #(HALF / 2);
      w[i] = dat_line;
      #(HALF / 2);
    end
    dat_oe_m = 1'b1;
    #(HALF / 2);
    clk_oe_m = 1'b1;
    #HALF;
    clk_oe_m = 1'b0;
    dat_oe_m = 1'b0;
    if (w[9] !== 1'b1 || ^w[8:0] !== 1'b1)
      rx_bad = 1'b1;
    got_q.push_back(w[7:0]);
    if (w[7:0] == 8'hEE)
      send_byte(8'hEE, 1'b0);
    else if (w[7:0] == 8'hFE)
      send_byte(last_tx, 1'b0);
    else
      send_byte(8'hFA, 1'b0);
    busy_m = 1'b0;
  end
endmodule // pskm_periph_model
`default_nettype wire

// ---- pskm_tx.v ----
// Host-to-peripheral word sender on the two-wire link
`timescale 1ns/1ps
`default_nettype none
`include "pskm_defs.vh"
module pskm_tx #(
  parameter INHIBIT_CYC = `PSKM_INHIBIT_CYC
) (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       start,
  input  wire [7:0] byte_in,
  input  wire       clk_fall,
  input  wire       line_clk,
  output wire       busy,
  output reg        done,
  output reg        clk_oe,
  output reg        dat_oe
);
  localparam S_IDLE = 2'h0;
  localparam S_HOLD = 2'h1;
  localparam S_BITS = 2'h2;
  localparam S_ACK  = 2'h3;

  reg [1:0]  state_reg;
  reg [31:0] cnt_reg;
  reg [9:0]  shift_reg;
  reg [3:0]  bit_reg;

  assign busy = (state_reg != S_IDLE);

  // ---------------------------------------------------------------------------
  // Inhibit, request to send, then shift on peripheral falling edges
  // ---------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      cnt_reg   <= 32'h0;
      shift_reg <= 10'h3FF;
      bit_reg   <= 4'h0;
      done      <= 1'b0;
      clk_oe    <= 1'b0;
      dat_oe    <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start) begin
            // Stop bit, odd parity, data LSB first
            shift_reg <= {1'b1, ~(^byte_in), byte_in};
            cnt_reg   <= 32'h0;
            clk_oe    <= 1'b1; // Pull clock low to inhibit
            state_reg <= S_HOLD;
          end
        end
        S_HOLD: begin
          cnt_reg <= cnt_reg + 32'h1;
          if (cnt_reg == INHIBIT_CYC) begin
            dat_oe    <= 1'b1; // Start bit 0
            clk_oe    <= 1'b0;
            bit_reg   <= 4'h0;
            state_reg <= S_BITS;
          end
        end
        S_BITS: begin
          if (clk_fall) begin
            // Change data while clock low; peripheral samples on rise
            dat_oe    <= ~shift_reg[0];
            shift_reg <= {1'b1, shift_reg[9:1]};
            bit_reg   <= bit_reg + 4'h1;
            if (bit_reg == 4'h9) begin
              dat_oe    <= 1'b0;
              state_reg <= S_ACK;
            end
          end
        end
        S_ACK: begin
          // Peripheral acknowledge bit, then signal done; lines already released
          if (clk_fall) begin
            state_reg <= S_IDLE;
            done      <= 1'b1;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule // pskm_tx
`default_nettype wire
